//--- inc/vliw_pkg.sv
// shared constants and carrier types for the vliw packet dispatcher
package vliw_pkg;
    // fetch unit geometry
    localparam int INSN_W = 32;
    localparam int SLOTS = 8;
    localparam int FETCH_W = 256;
    localparam int FETCH_BYTES = 32;
    localparam int REG_N = 16;
    localparam int UNITS = 8;
    // field positions inside one instruction
    localparam int CHAIN_BIT = 0;
    localparam int UNIT_LSB = 1;
    localparam int OFF_LSB = 4;
    localparam int SRC1_LSB = 14;
    localparam int BASE_LSB = 15;
    localparam int SRC2_LSB = 18;
    localparam int SIZE_LSB = 19;
    localparam int LONG_BIT = 21;
    localparam int CIRC_BIT = 22;
    localparam int XSRC_BIT = 22;
    localparam int DST_LSB = 23;
    localparam int DST_SIDE_BIT = 27;
    localparam int CLASS_LSB = 28;
    localparam int CREG_LSB = 30;
    // short and long offset widths
    localparam int OFF_SHORT_W = 5;
    localparam int OFF_LONG_W = 15;
    // base register used by long-offset accesses
    localparam logic [3:0] LONG_BASE_IDX = 4'hF;
    // instruction classes
    localparam logic [1:0] CLS_ALU = 2'h0;
    localparam logic [1:0] CLS_MUL = 2'h1;
    localparam logic [1:0] CLS_LOAD = 2'h2;
    localparam logic [1:0] CLS_STORE = 2'h3;
    // unit type in the low two bits of the unit number, side in bit 2
    localparam logic [1:0] TYPE_LOGIC = 2'h0;
    localparam logic [1:0] TYPE_SHIFT = 2'h1;
    localparam logic [1:0] TYPE_MUL = 2'h2;
    localparam logic [1:0] TYPE_DATA = 2'h3;
    localparam logic [2:0] LOGIC_UNIT_SIDE_A = 3'h0;
    localparam logic [2:0] SHIFT_UNIT_SIDE_A = 3'h1;
    localparam logic [2:0] MULTIPLY_UNIT_SIDE_A = 3'h2;
    localparam logic [2:0] DATA_ADDRESS_UNIT_SIDE_A = 3'h3;
    localparam logic [2:0] LOGIC_UNIT_SIDE_B = 3'h4;
    localparam logic [2:0] SHIFT_UNIT_SIDE_B = 3'h5;
    localparam logic [2:0] MULTIPLY_UNIT_SIDE_B = 3'h6;
    localparam logic [2:0] DATA_ADDRESS_UNIT_SIDE_B = 3'h7;
    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    // reset values
    localparam logic [31:0] START_ADDR_RST = 32'h0000_0000;
    localparam int CIRC_LOG2_RST = 5;

    // one instruction handed to a functional unit
    typedef struct packed {
        logic valid;           // unit receives an instruction
        logic exec;            // condition satisfied
        logic [31:0] insn;     // raw instruction
        logic [31:0] opnd_a;   // first operand or base
        logic [31:0] opnd_b;   // second operand or store data
        logic [31:0] addr;     // byte address for data units
        logic [3:0] be;        // byte enables for data units
    } issue_t;

    // result written back by a functional unit
    typedef struct packed {
        logic en;              // write this cycle
        logic [4:0] sel;       // side in bit 4, register below
        logic [31:0] data;     // value
    } wb_t;
endpackage

//--- src/vliw_packet_dispatch.sv
// fetch and dispatch front end with the two register files
`timescale 1ns/1ps
module vliw_packet_dispatch #(
    parameter logic [31:0] START_ADDR = vliw_pkg::START_ADDR_RST,
    parameter int CIRC_LOG2 = vliw_pkg::CIRC_LOG2_RST
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    input wire logic fetch_gnt,
    input wire logic fetch_rvalid,
    input wire logic [vliw_pkg::FETCH_W-1:0] fetch_data,
    input wire vliw_pkg::wb_t [vliw_pkg::UNITS-1:0] wb,
    output vliw_pkg::issue_t [vliw_pkg::UNITS-1:0] issue,
    output logic group_issued,
    output logic group_err
);
    import vliw_pkg::*;

    // fetch sequencer states
    typedef enum logic [1:0] {ST_FETCH, ST_WAIT, ST_ISSUE} state_t;

    state_t st_r;                            // sequencer state
    logic [FETCH_W-1:0] pkt_r;               // current fetch unit
    logic [2:0] ptr_r;                       // first slot of next group
    logic [31:0] addr_r;                     // fetch unit address
    logic [31:0] rf_r [2][REG_N];            // side a and side b files
    issue_t [UNITS-1:0] issue_r;             // registered unit bundles
    issue_t [UNITS-1:0] issue_nxt;           // bundles for this group
    logic grp_ok_r;                          // group issued pulse
    logic grp_err_r;                         // group refused pulse
    logic [SLOTS-1:0] in_grp;                // slots of current group
    logic [2:0] grp_last;                    // last slot of group
    logic bad;                               // group refused
    logic last_grp;                          // group ends fetch unit

    // instruction word of one slot
    function automatic logic [31:0] slot(input logic [FETCH_W-1:0] p, input int i);
        slot = p[i*INSN_W +: INSN_W];
    endfunction

    // byte lanes of one access
    function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
        case (sz)
            SZ_BYTE: lanes = 4'h1 << a;                     // single byte
            SZ_HALF: lanes = 4'h3 << {a[1], 1'b0};           // aligned half
            default: lanes = 4'hF;                          // whole word
        endcase
    endfunction

    assign fetch_req = (st_r == ST_FETCH) && run;
    assign fetch_addr = addr_r;
    assign issue = issue_r;
    assign group_issued = grp_ok_r;
    assign group_err = grp_err_r;
    assign last_grp = (grp_last == 3'h7);

    // group boundary search from the pointer on
    always_comb begin
        logic done;
        done = 1'b0;
        in_grp = '0;
        grp_last = 3'h7;
        for (int i = 0; i < SLOTS; i++) begin
            if (!done && i >= int'(ptr_r)) begin
                in_grp[i] = 1'b1;
                if (!pkt_r[i*INSN_W + CHAIN_BIT]) begin
                    done = 1'b1;
                    grp_last = 3'(i);
                end
            end
        end
    end

    // route each slot to its unit and check the group
    always_comb begin
        logic [31:0] w;
        logic [2:0] u;
        logic sd;
        logic ds;
        logic [1:0] cls;
        logic [UNITS-1:0] busy;
        logic [1:0] xr;
        logic [1:0] xw;
        logic [31:0] base;
        logic [31:0] off;
        logic [31:0] sum;
        logic [1:0] sz;
        w = '0;
        u = '0;
        sd = 1'b0;
        ds = 1'b0;
        cls = '0;
        busy = '0;
        xr = '0;
        xw = '0;
        base = '0;
        off = '0;
        sum = '0;
        sz = '0;
        bad = 1'b0;
        issue_nxt = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (in_grp[i]) begin
                w = slot(pkt_r, i);
                u = w[UNIT_LSB +: 3];
                sd = u[2];
                ds = w[DST_SIDE_BIT];
                cls = w[CLASS_LSB +: 2];
                sz = w[SIZE_LSB +: 2];
                // one unit, one slot
                if (busy[u]) begin
                    bad = 1'b1;
                end
                busy[u] = 1'b1;
                // class must suit the unit type
                case (cls)
                    CLS_MUL: if (u[1:0] != TYPE_MUL) bad = 1'b1;
                    CLS_ALU: if (u[1]) bad = 1'b1;
                    default: if (u[1:0] != TYPE_DATA) bad = 1'b1;
                endcase
                // cross path use, one read and one write per side
                if (((cls == CLS_ALU || cls == CLS_MUL) && w[XSRC_BIT])
                    || (cls == CLS_STORE && ds != sd)) begin
                    if (xr[sd]) bad = 1'b1;
                    xr[sd] = 1'b1;
                end
                if (cls != CLS_STORE && ds != sd) begin
                    if (xw[sd]) bad = 1'b1;
                    xw[sd] = 1'b1;
                end
                issue_nxt[u].valid = 1'b1;
                issue_nxt[u].insn = w;
                // condition register zero means never, field zero means always
                issue_nxt[u].exec = (w[CREG_LSB +: 2] == 2'h0)
                    || (rf_r[0][{2'h0, w[CREG_LSB +: 2]}] != 32'h0000_0000);
                if (cls == CLS_ALU || cls == CLS_MUL) begin
                    // operands straight from the files
                    issue_nxt[u].opnd_a = rf_r[sd][w[SRC1_LSB +: 4]];
                    issue_nxt[u].opnd_b = rf_r[sd ^ w[XSRC_BIT]][w[SRC2_LSB +: 4]];
                end else begin
                    // address from own side, data on either side
                    if (w[LONG_BIT]) begin
                        base = rf_r[sd][LONG_BASE_IDX];
                        off = 32'(w[OFF_LSB +: OFF_LONG_W]);
                    end else begin
                        base = rf_r[sd][w[BASE_LSB +: 4]];
                        off = 32'(w[OFF_LSB +: OFF_SHORT_W]);
                    end
                    sum = base + (off << sz);
                    if (w[CIRC_BIT]) begin
                        sum = (base & ~((32'h0000_0001 << CIRC_LOG2) - 32'h0000_0001))
                            | (sum & ((32'h0000_0001 << CIRC_LOG2) - 32'h0000_0001));
                    end
                    issue_nxt[u].opnd_a = base;
                    issue_nxt[u].opnd_b = rf_r[ds][w[DST_LSB +: 4]];
                    issue_nxt[u].addr = sum;
                    issue_nxt[u].be = lanes(sz, sum[1:0]);
                end
            end
        end
        if (bad) begin
            issue_nxt = '0;
        end
    end

    // fetch sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_FETCH;
        end else begin
            case (st_r)
                ST_FETCH: if (fetch_req && fetch_gnt) st_r <= ST_WAIT;
                ST_WAIT: if (fetch_rvalid) st_r <= ST_ISSUE;
                ST_ISSUE: if (last_grp) st_r <= ST_FETCH;
                default: st_r <= ST_FETCH;
            endcase
        end
    end

    // fetch unit capture, whole 256 bits at once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pkt_r <= '0;
        end else if (st_r == ST_WAIT && fetch_rvalid) begin
            pkt_r <= fetch_data;
        end
    end

    // slot pointer advances one group per clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_r <= '0;
        end else if (st_r == ST_WAIT && fetch_rvalid) begin
            ptr_r <= '0;
        end else if (st_r == ST_ISSUE) begin
            ptr_r <= grp_last + 3'h1;
        end
    end

    // fetch address steps by one fetch unit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_r <= START_ADDR;
        end else if (st_r == ST_ISSUE && last_grp) begin
            addr_r <= addr_r + 32'(FETCH_BYTES);
        end
    end

    // unit bundles and group pulses
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            issue_r <= '0;
            grp_ok_r <= 1'b0;
            grp_err_r <= 1'b0;
        end else begin
            issue_r <= (st_r == ST_ISSUE) ? issue_nxt : '0;
            grp_ok_r <= (st_r == ST_ISSUE) && !bad;
            grp_err_r <= (st_r == ST_ISSUE) && bad;
        end
    end

    // register files, all units may write in one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int s = 0; s < 2; s++) begin
                for (int r = 0; r < REG_N; r++) begin
                    rf_r[s][r] <= 32'h0000_0000;
                end
            end
        end else begin
            for (int k = 0; k < UNITS; k++) begin
                if (wb[k].en) begin
                    rf_r[wb[k].sel[4]][wb[k].sel[3:0]] <= wb[k].data;
                end
            end
        end
    end

    // helper: number of units fed this cycle
    logic [3:0] fed_cnt;
    always_comb begin
        fed_cnt = '0;
        for (int k = 0; k < UNITS; k++) begin
            fed_cnt = fed_cnt + 4'(issue_r[k].valid);
        end
    end

    // capture holds exactly the delivered fetch unit
    fetch_whole_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_WAIT && fetch_rvalid) |=> (pkt_r == $past(fetch_data)) && ptr_r == 3'h0)
        else $error("fetch unit not captured whole");

    // chained group feeds as many units as slots it spans
    chain_width_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_ISSUE && !bad) |=> fed_cnt == 4'($past(grp_last) - $past(ptr_r)) + 4'h1)
        else $error("group width does not match chain");

    // broken chain moves pointer just past it
    chain_break_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_ISSUE && !last_grp) |=> st_r == ST_ISSUE && ptr_r == $past(grp_last) + 3'h1)
        else $error("next group does not start after break");

    // every issue cycle answers with exactly one pulse
    one_per_clk_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_ISSUE) |=> (group_issued ^ group_err))
        else $error("issue cycle without single group");

    // no fetch while groups remain
    fetch_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_ISSUE && !last_grp) |=> !fetch_req ##0 $stable(fetch_addr))
        else $error("fetch requested before fetch unit drained");

    // last group steps address and returns to fetch
    fetch_next_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_ISSUE && last_grp) |=> st_r == ST_FETCH
            && fetch_addr == $past(fetch_addr) + 32'(FETCH_BYTES))
        else $error("fetch unit end not followed by fetch");

    // refused group feeds no unit
    conflict_a: assert property (@(posedge clk) disable iff (!rstn)
        group_err |-> fed_cnt == 4'h0)
        else $error("refused group reached a unit");

    // multiply units carry multiplies only
    mul_route_a: assert property (@(posedge clk) disable iff (!rstn)
        (issue[2].valid |-> issue[2].insn[CLASS_LSB +: 2] == CLS_MUL)
        and (issue[6].valid |-> issue[6].insn[CLASS_LSB +: 2] == CLS_MUL)
        and (issue[0].valid |-> issue[0].insn[CLASS_LSB +: 2] == CLS_ALU))
        else $error("multiply routed to wrong unit");

    // memory classes never land on a shift unit
    mem_route_a: assert property (@(posedge clk) disable iff (!rstn)
        (issue[1].valid |-> !issue[1].insn[CLASS_LSB + 1])
        and (issue[5].valid |-> !issue[5].insn[CLASS_LSB + 1]))
        else $error("memory access on compute unit");

    // word accesses use all lanes, bytes one lane
    lane_size_a: assert property (@(posedge clk) disable iff (!rstn)
        issue[3].valid |-> ((issue[3].insn[SIZE_LSB +: 2] == SZ_WORD) ? issue[3].be == 4'hF
            : (issue[3].insn[SIZE_LSB +: 2] != SZ_BYTE || $onehot(issue[3].be))))
        else $error("byte lanes do not match size");

    // always-true condition always executes
    cond_true_a: assert property (@(posedge clk) disable iff (!rstn)
        (issue[0].valid && issue[0].insn[CREG_LSB +: 2] == 2'h0) |-> issue[0].exec)
        else $error("unconditional instruction not executed");

    // memory classes never land on a logic unit either
    mem_logic_a: assert property (@(posedge clk) disable iff (!rstn)
        (issue[0].valid |-> !issue[0].insn[CLASS_LSB + 1])
        and (issue[4].valid |-> !issue[4].insn[CLASS_LSB + 1]))
        else $error("memory access on logic unit");

    // an untaken request keeps its state and address
    req_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (fetch_req && !fetch_gnt) |=> st_r == ST_FETCH && $stable(fetch_addr))
        else $error("fetch request dropped before grant");

    // full eight-wide group
    wide_c: cover property (@(posedge clk) disable iff (!rstn) fed_cnt == 4'h8);
    // eight single groups from one fetch unit
    narrow_c: cover property (@(posedge clk) disable iff (!rstn)
        (group_issued && fed_cnt == 4'h1) [*8]);
    // refused group
    refused_c: cover property (@(posedge clk) disable iff (!rstn) group_err);
    // condition false
    skip_c: cover property (@(posedge clk) disable iff (!rstn) issue[0].valid && !issue[0].exec);
    // store through a data unit
    store_c: cover property (@(posedge clk) disable iff (!rstn)
        issue[3].valid && issue[3].insn[CLASS_LSB +: 2] == CLS_STORE);
endmodule // vliw_packet_dispatch

//--- tb/prog_mem_model.sv
// program memory model serving whole fetch units to the dispatcher
`timescale 1ns/1ps
module prog_mem_model import vliw_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_gnt,
    output logic fetch_rvalid,
    output logic [FETCH_W-1:0] fetch_data
);
    logic [FETCH_W-1:0] q [$]; // fetch units queued by the bench
    logic pend_r; // a request has been taken
    logic hold_r; // slow mode grants one cycle late
    int wait_r; // remaining answer delay
    // bench loads the next fetch unit
    function void push(input logic [FETCH_W-1:0] l);
        q.push_back(l);
    endfunction
    // grant only while a request stands
    assign fetch_gnt = fetch_req && (hold_r || !slow);
    // answer with one whole unit, data garbled outside the valid pulse
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_r <= 1'b0;
            hold_r <= 1'b0;
            wait_r <= 0;
            fetch_rvalid <= 1'b0;
            fetch_data <= '0;
        end else begin
            hold_r <= fetch_req && !fetch_gnt;
            fetch_rvalid <= 1'b0;
            fetch_data <= ~fetch_data;
            if (fetch_req && fetch_gnt) begin
                pend_r <= 1'b1;
                wait_r <= slow ? 3 : 0;
            end else if (pend_r && q.size() > 0) begin
                if (wait_r > 0) begin
                    wait_r <= wait_r - 1;
                end else begin
                    fetch_rvalid <= 1'b1;
                    fetch_data <= q.pop_front();
                    pend_r <= 1'b0;
                end
            end
        end
    end
endmodule // prog_mem_model

//--- tb/vliw_packet_dispatch_tb.sv
// self-checking bench for the packet dispatcher
`timescale 1ns/1ps
module vliw_packet_dispatch_tb import vliw_pkg::*; ;
    logic clk, rstn, run, slow, fetch_req, fetch_gnt, fetch_rvalid, group_issued, group_err;
    logic [31:0] fetch_addr;
    logic [31:0] exp_addr; // expected fetch address
    logic [FETCH_W-1:0] fetch_data;
    wb_t [UNITS-1:0] wb; // write-back ports
    issue_t [UNITS-1:0] issue;
    issue_t [UNITS-1:0] last_iss; // last group seen
    int n_errors, n_tests;
    vliw_packet_dispatch vliw_packet_dispatch_inst (.clk(clk), .rstn(rstn), .run(run),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_gnt(fetch_gnt),
        .fetch_rvalid(fetch_rvalid), .fetch_data(fetch_data), .wb(wb), .issue(issue),
        .group_issued(group_issued), .group_err(group_err));
    prog_mem_model prog_mem_model_inst (.clk(clk), .rstn(rstn), .slow(slow),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_gnt(fetch_gnt),
        .fetch_rvalid(fetch_rvalid), .fetch_data(fetch_data));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // counts and verdict
    task finish_test;
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // compare one value
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // units receiving an instruction now
    function logic [31:0] mask();
        mask = '0;
        for (int u = 0; u < UNITS; u++) mask[u] = issue[u].valid;
    endfunction
    // instruction of the class matching its unit
    function logic [31:0] ins(input logic [2:0] u, input logic ch, input logic [1:0] cond);
        ins = '0;
        ins[CLASS_LSB+:2] = (u[1:0] == TYPE_MUL) ? CLS_MUL : (u[1:0] == TYPE_DATA) ? CLS_LOAD : CLS_ALU;
        ins[UNIT_LSB+:3] = u;
        ins[CHAIN_BIT] = ch;
        ins[CREG_LSB+:2] = cond;
        ins[DST_SIDE_BIT] = u[2];
    endfunction
    // slot i on unit i with chain bits ch
    function logic [FETCH_W-1:0] line_of(input logic [7:0] ch);
        for (int i = 0; i < SLOTS; i++) line_of[i*32+:32] = ins(3'(i), ch[i], 2'h0);
    endfunction
    // serve one unit and follow its groups cycle by cycle
    task run_pkt(input logic [FETCH_W-1:0] l, input int n, input logic [7:0] m [8],
        input logic [7:0] e);
        int k;
        prog_mem_model_inst.push(l);
        k = 0;
        while (group_issued !== 1'b1 && group_err !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        if (k == 40) begin
            n_errors++;
            finish_test();
        end
        for (int g = 0; g < n; g++) begin
            check(group_err, e[g], "refusal");
            check(group_issued, !e[g], "issue pulse");
            check(mask(), m[g], "unit mask");
            check(fetch_req, g == n - 1, "fetch request");
            last_iss = issue;
            @(negedge clk);
        end
        check(group_issued | group_err, 0, "extra group");
        check(fetch_addr, exp_addr + 32, "fetch address");
        exp_addr += 32;
    endtask
    // one register write through write-back port 0
    task wr(input logic [4:0] sel, input logic [31:0] d);
        wb[0] = {1'b1, sel, d};
        @(negedge clk);
        wb[0] = '0;
    endtask
    // group sizes 2,1,5 then eight singles slowly then one of eight
    task t_groups;
        run_pkt(line_of(8'h79), 3, '{8'h03, 8'h04, 8'hF8, 0, 0, 0, 0, 0}, 0);
        slow = 1'b1;
        run_pkt(line_of(8'h00), 8, '{1, 2, 4, 8, 16, 32, 64, 128}, 0);
        slow = 1'b0;
        run_pkt(line_of(8'h7F), 1, '{8'hFF, 0, 0, 0, 0, 0, 0, 0}, 0);
    endtask
    // every group of this unit is refused
    task t_refuse;
        logic [FETCH_W-1:0] l;
        l = line_of(8'h00);
        l[31:0] = ins(3'h0, 1'b1, 2'h0);
        l[63:32] = ins(3'h0, 1'b0, 2'h0);
        l[64+CLASS_LSB+:2] = CLS_MUL;
        l[64+UNIT_LSB+:3] = SHIFT_UNIT_SIDE_A;
        l[96+CLASS_LSB+:2] = CLS_ALU;
        l[159:128] = ins(3'h0, 1'b1, 2'h0);
        l[191:160] = ins(3'h1, 1'b0, 2'h0);
        l[128+XSRC_BIT] = 1'b1;
        l[160+XSRC_BIT] = 1'b1;
        l[223:192] = ins(3'h4, 1'b1, 2'h0);
        l[192+DST_SIDE_BIT] = 1'b0;
        l[224+DST_SIDE_BIT] = 1'b0;
        run_pkt(l, 5, '{0, 0, 0, 0, 0, 0, 0, 0}, 8'h1F);
    endtask
    // a group of seven then the instruction under test alone
    task t_fill(input logic [31:0] x, input logic [7:0] m7);
        logic [FETCH_W-1:0] l;
        for (int i = 0; i < 7; i++) l[i*32+:32] = ins(3'(i < 3 ? i : i + 1), i != 6, 2'h0);
        l[255:224] = x;
        run_pkt(l, 2, '{8'hF7, m7, 0, 0, 0, 0, 0, 0}, 0);
    endtask
    // condition register gates execution, operands from own file
    task t_cond;
        logic [31:0] x;
        x = ins(3'h0, 1'b0, 2'h1);
        x[SRC1_LSB+:4] = 4'h1;
        t_fill(x, 8'h01);
        check(last_iss[0].exec, 0, "exec false");
        check(last_iss[0].opnd_a, 0, "operand");
        wr(5'h01, 32'h0000_0005);
        t_fill(x, 8'h01);
        check(last_iss[0].exec, 1, "exec true");
        check(last_iss[0].opnd_a, 32'h0000_0005, "operand");
    endtask
    // address and lanes for sizes, circular and long offsets, then a cross store
    task automatic t_load;
        logic [31:0] x;
        logic [1:0] sz [6] = '{SZ_BYTE, SZ_HALF, SZ_WORD, SZ_WORD, SZ_WORD, SZ_WORD};
        logic [14:0] off [6] = '{15'h5, 15'h3, 15'h3, 15'hA, 15'h100, 15'h1};
        logic [31:0] ea [6] = '{32'h105, 32'h106, 32'h10C, 32'h108, 32'h600, 32'h104};
        logic [3:0] be [6] = '{4'h2, 4'hC, 4'hF, 4'hF, 4'hF, 4'hF};
        wr(5'h02, 32'h0000_0100);
        wr(5'h0F, 32'h0000_0200);
        wr(5'h13, 32'h0000_00AA);
        for (int i = 0; i < 6; i++) begin
            x = ins(3'h3, 1'b0, 2'h0);
            if (i == 5) x[CLASS_LSB+:2] = CLS_STORE;
            x[SIZE_LSB+:2] = sz[i];
            x[OFF_LSB+:15] = off[i];
            if (i != 4) x[BASE_LSB+:4] = 4'h2;
            x[CIRC_BIT] = (i == 3);
            x[LONG_BIT] = (i == 4);
            x[DST_SIDE_BIT] = 1'b1;
            x[DST_LSB+:4] = 4'h3;
            t_fill(x, 8'h08);
            check(last_iss[3].addr, ea[i], "address");
            check(last_iss[3].be, be[i], "lanes");
            if (i == 5) check(last_iss[3].opnd_b, 32'h0000_00AA, "store data");
        end
    endtask
    // reset, then the scenarios in turn
    initial begin
        rstn = 1'b0;
        run = 1'b0;
        slow = 1'b0;
        wb = '0;
        n_errors = 0;
        n_tests = 0;
        exp_addr = START_ADDR_RST;
        repeat (16) @(negedge clk);
        check(fetch_addr, START_ADDR_RST, "reset address");
        rstn = 1'b1;
        @(negedge clk);
        check(fetch_req, 0, "held request");
        run = 1'b1;
        t_groups();
        t_refuse();
        t_cond();
        t_load();
        finish_test();
    end
endmodule // vliw_packet_dispatch_tb
